//--- core/swl_pkg.sv
// Package of the flash wear-level controller: register map, opcodes,
// status bits and the state records. Assumes an 8-bit byte-wide bus.
package swl_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] A_INSTR      = 8'h77;
	localparam logic [7:0] A_LPAGE_MID  = 8'h78;
	localparam logic [7:0] A_LPAGE_HIGH = 8'h79;
	localparam logic [7:0] A_FADDR_LOW  = 8'h80;
	localparam logic [7:0] A_FADDR_MID  = 8'h81;
	localparam logic [7:0] A_FADDR_HIGH = 8'h82;
	localparam logic [7:0] A_TX_BYTE    = 8'h83;
	localparam logic [7:0] A_TALLY_CTL  = 8'h84;
	localparam logic [7:0] A_BM_ADDR    = 8'h85;
	localparam logic [7:0] A_BM_STROBE  = 8'h86;
	localparam logic [7:0] A_CLK_DIV    = 8'h87;
	localparam logic [7:0] A_RX_BYTE    = 8'h88;
	localparam logic [7:0] A_TALLY_LOW  = 8'h89;
	localparam logic [7:0] A_TALLY_MID  = 8'h90;
	localparam logic [7:0] A_TALLY_HIGH = 8'h91;
	localparam logic [7:0] A_GATE       = 8'h92;
	localparam logic [7:0] A_MAP_LOW    = 8'h93;
	localparam logic [7:0] A_MAP_HIGH   = 8'h94;
	localparam logic [7:0] A_BM_RDBACK  = 8'h95;
	localparam logic [7:0] A_STATUS     = 8'hFF;

	// ---------------------------------------------------------------
	// Fields, opcodes, sizes
	// ---------------------------------------------------------------
	localparam int TALLY_EN_BIT  = 7;
	localparam int GATE_BIT      = 0;
	localparam int ST_BYTE_DONE  = 0;
	localparam int ST_BUSY       = 1;
	localparam int ST_SELECTED   = 2;
	localparam int ST_Q_EMPTY    = 3;
	localparam int ST_Q_FULL     = 4;
	localparam int ST_UPDATING   = 5;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
	localparam logic [7:0] OP_BULK_ERASE   = 8'hC7;
	localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
	localparam int SECTORS     = 8;
	localparam int PAGES       = 2048;
	localparam int BM_ENTRIES  = 256;
	localparam logic [7:0] BM_LAST_ENTRY = 8'hFF;
	localparam logic [2:0] LAST_BIT      = 3'h7;
	localparam logic [7:0] ZERO_BYTE     = 8'h00;
	localparam int FIFO_DEPTH  = 16;

	typedef enum logic [1:0] {
		SWL_SER_IDLE = 2'b00,
		SWL_SER_LOW  = 2'b01,
		SWL_SER_HIGH = 2'b11
	} swl_ser_t;

	typedef enum logic {
		SWL_MNT_IDLE = 1'b0,
		SWL_MNT_WALK = 1'b1
	} swl_mnt_t;

	typedef struct packed {
		logic [7:0] instr;
		logic [7:0] lmid;
		logic [7:0] lhigh;
		logic [7:0] alow;
		logic [7:0] amid;
		logic [7:0] ahigh;
		logic [7:0] txb;
		logic [7:0] tally_ctl;
		logic [7:0] bm_addr;
		logic [7:0] bm_strobe;
		logic [7:0] div;
		logic [7:0] gate;
	} swl_regs_t;

	typedef struct packed {
		swl_regs_t  r;
		logic [7:0]  rx;
		logic [23:0] tally;
		logic [10:0] mapped;
		logic [7:0]  bm_rd;
		logic        ack;
		logic [7:0]  rdata;
		logic [2:0]  din_sync;
		logic        din;
		swl_ser_t    st;
		logic [7:0]  divcnt;
		logic [2:0]  bitcnt;
		logic [7:0]  shreg;
		logic        sclk;
		logic        cs_n;
		logic        mosi;
		logic        byte_done;
		swl_mnt_t    mst;
		logic        bulk;
		logic [2:0]  sector;
		logic [7:0]  widx;
	} swl_state_t;

	typedef struct packed {
		logic [4:0] wptr;
		logic [4:0] rptr;
	} swl_fifo_state_t;

endpackage

//--- core/swl_ctrl.sv
// Serial flash sequencer with wear-level bookkeeping, byte-wide bus slave.
// Assumes one 100 MHz clock, a bus master that holds stb until ack, and a
// mode-0 serial flash on the four link pins.

// ---------------------------------------------------------------
// Byte queue between the bus and the serial engine
// ---------------------------------------------------------------
module swl_fifo
	import swl_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr_ff;
	logic [AW:0]      rptr_ff;
	logic [AW:0]      nxt_wptr;
	logic [AW:0]      nxt_rptr;
	// Extra pointer bit tells full from empty
	always_comb begin
		in_ready  = (wptr_ff[AW] == rptr_ff[AW])
			|| (wptr_ff[AW-1:0] != rptr_ff[AW-1:0]);
		out_valid = (wptr_ff != rptr_ff);
		out_data  = mem[rptr_ff[AW-1:0]];
		nxt_wptr  = wptr_ff + (AW+1)'(in_valid && in_ready);
		nxt_rptr  = rptr_ff + (AW+1)'(out_valid && out_ready);
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
		end
		if (in_valid && in_ready) begin
			mem[wptr_ff[AW-1:0]] <= in_data;
		end
	end
endmodule

// ---------------------------------------------------------------
// Controller top
// ---------------------------------------------------------------
module swl_ctrl
	import swl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] wb_adr_i,
	input  wire logic [7:0] wb_dat_i,
	output logic      [7:0] wb_dat_o,
	input  wire logic       wb_we_i,
	input  wire logic       wb_stb_i,
	output logic            wb_ack_o,
	output logic            serial_clock_out,
	input  wire logic       serial_in_from_flash,
	output logic            serial_out_to_flash,
	output logic            flash_select_n
);
	swl_state_t  s_ff;
	swl_state_t  nxt_s;
	// Bookkeeping memories
	logic [23:0] tally_mem  [SECTORS];
	logic [10:0] page_table [PAGES];
	logic [7:0]  bitmap_mem [BM_ENTRIES];
	logic        q_in_valid;
	logic        q_in_ready;
	logic        q_out_valid;
	logic        q_out_ready;
	logic [7:0]  q_out_data;
	logic [7:0]  q_in_data;
	logic        access;
	logic        take;
	logic        enq_reg;
	logic [10:0] lpage;
	logic [10:0] ppage;
	logic [23:0] faddr;
	logic [7:0]  status;
	logic        release_cs;
	logic        tally_we;
	logic [2:0]  tally_wa;
	logic        bm_we;
	logic [7:0]  bm_wa;
	logic [7:0]  bm_wd;
	logic        map_we;
	swl_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_queue (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (q_in_valid),
		.in_ready  (q_in_ready),
		.in_data   (q_in_data),
		.out_valid (q_out_valid),
		.out_ready (q_out_ready),
		.out_data  (q_out_data)
	);
	assign wb_ack_o            = s_ff.ack;
	assign wb_dat_o            = s_ff.rdata;
	assign serial_clock_out    = s_ff.sclk;
	assign serial_out_to_flash = s_ff.mosi;
	assign flash_select_n      = s_ff.cs_n;
	always_comb begin
		nxt_s = s_ff;
		lpage = 11'({s_ff.r.lhigh, s_ff.r.lmid});
		faddr = {s_ff.r.ahigh, s_ff.r.amid, s_ff.r.alow};
		ppage = faddr[18:8];
		status = ZERO_BYTE;
		status[ST_BYTE_DONE] = s_ff.byte_done;
		status[ST_BUSY]      = (s_ff.st != SWL_SER_IDLE);
		status[ST_SELECTED]  = !s_ff.cs_n;
		status[ST_Q_EMPTY]   = !q_out_valid;
		status[ST_Q_FULL]    = !q_in_ready;
		status[ST_UPDATING]  = (s_ff.mst == SWL_MNT_WALK);
		// ---------------------------------------------------------------
		// Bus slave
		// ---------------------------------------------------------------
		access = wb_stb_i && !s_ff.ack;
		enq_reg = (wb_adr_i == A_INSTR) || (wb_adr_i == A_TX_BYTE)
			|| (wb_adr_i == A_FADDR_LOW) || (wb_adr_i == A_FADDR_MID)
			|| (wb_adr_i == A_FADDR_HIGH);
		q_in_valid = access && wb_we_i && enq_reg
			&& s_ff.r.gate[GATE_BIT];
		q_in_data = wb_dat_i;
		// A full queue holds off the acknowledge instead of losing a byte
		take = access && !(q_in_valid && !q_in_ready);
		nxt_s.ack = take;
		if (take && wb_we_i) begin
			unique case (wb_adr_i)
				A_INSTR:      nxt_s.r.instr = wb_dat_i;
				A_LPAGE_MID:  nxt_s.r.lmid = wb_dat_i;
				A_LPAGE_HIGH: nxt_s.r.lhigh = wb_dat_i;
				A_FADDR_LOW:  nxt_s.r.alow = wb_dat_i;
				A_FADDR_MID:  nxt_s.r.amid = wb_dat_i;
				A_FADDR_HIGH: nxt_s.r.ahigh = wb_dat_i;
				A_TX_BYTE:    nxt_s.r.txb = wb_dat_i;
				A_TALLY_CTL:  nxt_s.r.tally_ctl = wb_dat_i;
				A_BM_ADDR:    nxt_s.r.bm_addr = wb_dat_i;
				A_BM_STROBE:  nxt_s.r.bm_strobe = wb_dat_i;
				A_CLK_DIV:    nxt_s.r.div = wb_dat_i;
				A_GATE:       nxt_s.r.gate = wb_dat_i;
				default:      nxt_s.r = s_ff.r;
			endcase
		end
		if (take && !wb_we_i) begin
			unique case (wb_adr_i)
				A_INSTR:      nxt_s.rdata = s_ff.r.instr;
				A_LPAGE_MID:  nxt_s.rdata = s_ff.r.lmid;
				A_LPAGE_HIGH: nxt_s.rdata = s_ff.r.lhigh;
				A_FADDR_LOW:  nxt_s.rdata = s_ff.r.alow;
				A_FADDR_MID:  nxt_s.rdata = s_ff.r.amid;
				A_FADDR_HIGH: nxt_s.rdata = s_ff.r.ahigh;
				A_TX_BYTE:    nxt_s.rdata = s_ff.r.txb;
				A_TALLY_CTL:  nxt_s.rdata = s_ff.r.tally_ctl;
				A_BM_ADDR:    nxt_s.rdata = s_ff.r.bm_addr;
				A_BM_STROBE:  nxt_s.rdata = s_ff.r.bm_strobe;
				A_CLK_DIV:    nxt_s.rdata = s_ff.r.div;
				A_GATE:       nxt_s.rdata = s_ff.r.gate;
				A_RX_BYTE:    nxt_s.rdata = s_ff.rx;
				A_TALLY_LOW:  nxt_s.rdata = s_ff.tally[7:0];
				A_TALLY_MID:  nxt_s.rdata = s_ff.tally[15:8];
				A_TALLY_HIGH: nxt_s.rdata = s_ff.tally[23:16];
				A_MAP_LOW:    nxt_s.rdata = s_ff.mapped[7:0];
				A_MAP_HIGH:   nxt_s.rdata = {5'h00, s_ff.mapped[10:8]};
				A_BM_RDBACK:  nxt_s.rdata = s_ff.bm_rd;
				A_STATUS:     nxt_s.rdata = status;
				default:      nxt_s.rdata = ZERO_BYTE;
			endcase
		end
		// ---------------------------------------------------------------
		// Readback of the bookkeeping memories
		// ---------------------------------------------------------------
		if (s_ff.r.tally_ctl[TALLY_EN_BIT]) begin
			nxt_s.tally = tally_mem[s_ff.r.tally_ctl[2:0]];
		end
		if (take && wb_we_i && (wb_adr_i == A_BM_STROBE)) begin
			nxt_s.bm_rd = bitmap_mem[s_ff.r.bm_addr];
		end
		nxt_s.mapped = page_table[lpage];
		// ---------------------------------------------------------------
		// Serial input synchroniser: stage 0 feeds stage 1 only
		// ---------------------------------------------------------------
		nxt_s.din_sync = {s_ff.din_sync[1:0], serial_in_from_flash};
		if (s_ff.din_sync[1] == s_ff.din_sync[2]) begin
			nxt_s.din = s_ff.din_sync[2];
		end
		// ---------------------------------------------------------------
		// Serial engine, mode 0, half period of div+1 clocks
		// ---------------------------------------------------------------
		q_out_ready = 1'b0;
		release_cs  = 1'b0;
		unique case (s_ff.st)
			SWL_SER_IDLE: begin
				// Bookkeeping walk holds the link so counts see a closed frame
				if (q_out_valid && (s_ff.mst == SWL_MNT_IDLE)) begin
					q_out_ready  = 1'b1;
					nxt_s.shreg  = q_out_data;
					nxt_s.mosi   = q_out_data[7];
					nxt_s.cs_n   = 1'b0;
					nxt_s.bitcnt = '0;
					nxt_s.divcnt = '0;
					nxt_s.st     = SWL_SER_LOW;
				end else if (!s_ff.cs_n && !q_out_valid
						&& !s_ff.r.gate[GATE_BIT]) begin
					nxt_s.cs_n = 1'b1;
					release_cs = 1'b1;
				end
			end
			SWL_SER_LOW: begin
				if (s_ff.divcnt == s_ff.r.div) begin
					nxt_s.divcnt = '0;
					nxt_s.sclk   = 1'b1;
					nxt_s.shreg  = {s_ff.shreg[6:0], s_ff.din};
					nxt_s.st     = SWL_SER_HIGH;
				end else begin
					nxt_s.divcnt = s_ff.divcnt + 8'h01;
				end
			end
			SWL_SER_HIGH: begin
				if (s_ff.divcnt == s_ff.r.div) begin
					nxt_s.divcnt = '0;
					nxt_s.sclk   = 1'b0;
					if (s_ff.bitcnt == LAST_BIT) begin
						nxt_s.rx = s_ff.shreg;
						nxt_s.st = SWL_SER_IDLE;
					end else begin
						nxt_s.bitcnt = s_ff.bitcnt + 3'h1;
						nxt_s.mosi   = s_ff.shreg[7];
						nxt_s.st     = SWL_SER_LOW;
					end
				end else begin
					nxt_s.divcnt = s_ff.divcnt + 8'h01;
				end
			end
		endcase

		// Done flag: a byte finishing wins over the read that clears it
		if (take && !wb_we_i && (wb_adr_i == A_STATUS)) begin
			nxt_s.byte_done = 1'b0;
		end
		if ((s_ff.st == SWL_SER_HIGH) && (s_ff.divcnt == s_ff.r.div)
				&& (s_ff.bitcnt == LAST_BIT)) begin
			nxt_s.byte_done = 1'b1;
		end

		// ---------------------------------------------------------------
		// Wear-level bookkeeping, run when the instruction frame closes
		// ---------------------------------------------------------------
		tally_we = 1'b0;
		tally_wa = '0;
		bm_we    = 1'b0;
		bm_wa    = '0;
		bm_wd    = ZERO_BYTE;
		map_we   = 1'b0;
		unique case (s_ff.mst)
			SWL_MNT_IDLE: begin
				if (release_cs && ((s_ff.r.instr == OP_SECTOR_ERASE)
						|| (s_ff.r.instr == OP_BULK_ERASE))) begin
					nxt_s.bulk   = (s_ff.r.instr == OP_BULK_ERASE);
					nxt_s.sector = s_ff.r.ahigh[2:0];
					nxt_s.widx   = '0;
					nxt_s.mst    = SWL_MNT_WALK;
				end else if (release_cs
						&& (s_ff.r.instr == OP_PAGE_PROG)) begin
					map_we = 1'b1;
					bm_we  = 1'b1;
					bm_wa  = ppage[10:3];
					bm_wd  = bitmap_mem[ppage[10:3]]
						| (8'h01 << ppage[2:0]);
				end
			end
			SWL_MNT_WALK: begin
				// One entry a cycle; a sector owns bitmap entries with top bits = sector and the tally entry = sector
				if (s_ff.widx < 8'(SECTORS) && (s_ff.bulk
						|| (s_ff.widx[2:0] == s_ff.sector))) begin
					tally_we = 1'b1;
					tally_wa = s_ff.widx[2:0];
				end
				if (s_ff.bulk || (s_ff.widx[7:5] == s_ff.sector)) begin
					bm_we = 1'b1;
					bm_wa = s_ff.widx;
					bm_wd = ZERO_BYTE;
				end
				nxt_s.widx = s_ff.widx + 8'h01;
				if (s_ff.widx == BM_LAST_ENTRY) begin
					nxt_s.mst = SWL_MNT_IDLE;
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// State and memory registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			s_ff      <= '0;
			s_ff.cs_n <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Counts and bitmap start clean; no nonvolatile restore here
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < SECTORS; i++) begin
				tally_mem[i] <= '0;
			end
			for (int j = 0; j < BM_ENTRIES; j++) begin
				bitmap_mem[j] <= ZERO_BYTE;
			end
		end else begin
			if (tally_we) begin
				tally_mem[tally_wa] <= tally_mem[tally_wa] + 24'h000001;
			end
			if (bm_we) begin
				bitmap_mem[bm_wa] <= bm_wd;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (map_we) begin
			page_table[lpage] <= ppage;
		end
	end
endmodule

//--- verification/swl_flash_model.sv
// Behavioural serial flash: logs each byte shifted in, answers REPLY.
// Assumes a mode 0 link, select active low, bytes MSB first.
module swl_flash_model #(
	parameter logic [7:0] REPLY = 8'hA5
) (
	input  wire logic sclk,
	input  wire logic sel_n,
	input  wire logic mosi,
	output logic      miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	logic [7:0] osh;
	int         n;
	logic [7:0] log_q [$];

	initial miso = 1'b0;
	always @(negedge sel_n) begin
		n = 0;
		osh = REPLY;
		miso = REPLY[7];
	end
	// Capture on the rising clock, top bit first
	always @(posedge sclk) begin
		if (!sel_n) begin
			sh = {sh[6:0], mosi};
			n = n + 1;
			if (n % 8 == 0)
				log_q.push_back(sh);
		end
	end
	always @(negedge sclk) begin
		if (!sel_n) begin
			osh = {osh[6:0], osh[7]};
			miso = osh[7];
		end
	end
	// Released line flips so a stale bit cannot pass as data
	always @(posedge sel_n) miso = ~miso;
endmodule

//--- verification/swl_ctrl_sva.sv
// Checker of the controller ports: bus handshake and serial frame form.
// Assumes one clock and the synchronous active-high reset of the block.
module swl_ctrl_sva (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [7:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic [7:0] wb_dat_o,
	input wire logic       wb_we_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       serial_clock_out,
	input wire logic       serial_in_from_flash,
	input wire logic       serial_out_to_flash,
	input wire logic       flash_select_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_read_taken;
		wb_stb_i && !wb_we_i && !wb_ack_o;
	endsequence
	sequence s_ack_once;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	chk_read_ack: assert property (s_read_taken |=> s_ack_once)
		else $error("read not acknowledged in one cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("acknowledge without strobe");
	chk_data_hold: assert property (wb_ack_o |=> $stable(wb_dat_o))
		else $error("read data moved after acknowledge");
	chk_reset_idle: assert property (@(posedge clk) disable iff (1'b0)
		reset |=> !wb_ack_o && flash_select_n && !serial_clock_out
		&& wb_dat_o == 8'h00)
		else $error("outputs not idle after reset");
	chk_sclk_idle: assert property (flash_select_n |-> !serial_clock_out)
		else $error("serial clock active while deselected");
	chk_sel_start: assert property ($fell(flash_select_n)
		|-> !serial_clock_out)
		else $error("frame opened with clock high");
	chk_mosi_stable: assert property ($rose(serial_clock_out)
		|-> $stable(serial_out_to_flash))
		else $error("data changed at rising serial clock");
endmodule

bind swl_ctrl swl_ctrl_sva i_chk (
	.clk                  (clk),
	.reset                (reset),
	.wb_adr_i             (wb_adr_i),
	.wb_dat_i             (wb_dat_i),
	.wb_dat_o             (wb_dat_o),
	.wb_we_i              (wb_we_i),
	.wb_stb_i             (wb_stb_i),
	.wb_ack_o             (wb_ack_o),
	.serial_clock_out     (serial_clock_out),
	.serial_in_from_flash (serial_in_from_flash),
	.serial_out_to_flash  (serial_out_to_flash),
	.flash_select_n       (flash_select_n)
);

//--- verification/swl_ctrl_test.sv
// Testbench of the controller: byte bus tasks and register scenarios.
// Assumes the checker binds itself and a flash model sits on the link.
module swl_ctrl_test
	import swl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] RPLY = 8'hA5;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [7:0] dat = 8'h00;
	logic       we = 1'b0;
	logic       stb = 1'b0;
	logic [7:0] rd;
	logic       ack, sclk, miso, mosi, sel_n;
	logic       sck_q = 1'b0;
	logic [7:0] st;
	int         n_fail = 0;
	int         n_compared = 0;
	int         cyc = 0;
	int         per = 0;
	int         b;
	logic [7:0] rw_a [10] = '{A_INSTR, A_LPAGE_MID, A_LPAGE_HIGH,
		A_FADDR_LOW, A_FADDR_MID, A_FADDR_HIGH, A_TX_BYTE, A_BM_ADDR,
		A_CLK_DIV, A_GATE};
	logic [7:0] pp_a [5] = '{A_INSTR, A_FADDR_LOW, A_FADDR_MID,
		A_FADDR_HIGH, A_TX_BYTE};
	logic [7:0] pp_d [5] = '{OP_PAGE_PROG, 8'h11, 8'hAB, 8'h03, 8'h5A};

	always #5 clk = ~clk;

	swl_ctrl i_dut (.clk(clk), .reset(reset), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_dat_o(rd), .wb_we_i(we), .wb_stb_i(stb),
		.wb_ack_o(ack), .serial_clock_out(sclk),
		.serial_in_from_flash(miso), .serial_out_to_flash(mosi),
		.flash_select_n(sel_n));
	swl_flash_model #(.REPLY(RPLY)) i_flash (.sclk(sclk), .sel_n(sel_n),
		.mosi(mosi), .miso(miso));

	// Serial clock period in system clocks, rise to rise
	always @(posedge clk) begin
		sck_q <= sclk;
		cyc <= cyc + 1;
		if (sclk && !sck_q) begin
			per <= cyc + 1;
			cyc <= 0;
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	// Strobe held until ack is seen; data taken at that same edge
	task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 4000);
		if (ack !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: no acknowledge", $time);
		end
		st = rd;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(a, 1'b1, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		acc(a, 1'b0, 8'h00);
		chk(st, e);
	endtask
	task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
		int k;
		k = 0;
		do begin
			acc(A_STATUS, 1'b0, 8'h00);
			k++;
		end while ((st & m) !== v && k < 2000);
		chk(st & m, v);
	endtask
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#400000;
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rdc(A_STATUS, 8'h08);
		foreach (rw_a[i]) begin
			rdc(rw_a[i], 8'h00);
			wr(rw_a[i], rw_a[i] ^ 8'h3C);
			rdc(rw_a[i], rw_a[i] ^ 8'h3C);
		end
		wr(A_RX_BYTE, 8'hFF);
		rdc(A_RX_BYTE, 8'h00);
		rdc(8'h20, 8'h00);
		rdc(A_STATUS, 8'h08);
		chk(8'(i_flash.log_q.size()), 8'h00);
		$display("test registers done");
		// Queue filled until writes are held off, then drained
		wr(A_CLK_DIV, 8'h07);
		wr(A_GATE, 8'h01);
		wr(A_INSTR, 8'h03);
		for (int i = 0; i < 17; i++)
			wr(A_TX_BYTE, 8'(i));
		acc(A_STATUS, 1'b0, 8'h00);
		chk(st & 8'h10, 8'h10);
		wait_st(8'h0A, 8'h08);
		chk(8'(per), 8'h10);
		chk(8'(i_flash.log_q.size()), 8'h12);
		chk(i_flash.log_q[0], 8'h03);
		for (int i = 0; i < 17; i++)
			chk(i_flash.log_q[i + 1], 8'(i));
		wr(A_GATE, 8'h00);
		wait_st(8'h26, 8'h00);
		rdc(A_RX_BYTE, RPLY);
		$display("test queue done");
		b = i_flash.log_q.size();
		wr(A_LPAGE_MID, 8'h34);
		wr(A_LPAGE_HIGH, 8'h05);
		wr(A_GATE, 8'h01);
		foreach (pp_a[i]) begin
			wr(pp_a[i], pp_d[i]);
			wait_st(8'h01, 8'h01);
		end
		wait_st(8'h0A, 8'h08);
		foreach (pp_d[i])
			chk(i_flash.log_q[b + i], pp_d[i]);
		wr(A_GATE, 8'h00);
		wait_st(8'h26, 8'h00);
		rdc(A_MAP_LOW, 8'hAB);
		rdc(A_MAP_HIGH, 8'h03);
		wr(A_BM_ADDR, 8'h75);
		wr(A_BM_STROBE, 8'h01);
		rdc(A_BM_RDBACK, 8'h08);
		$display("test page program done");
		wr(A_CLK_DIV, 8'h02);
		wr(A_GATE, 8'h01);
		wr(A_INSTR, OP_SECTOR_ERASE);
		wait_st(8'h01, 8'h01);
		wr(A_FADDR_MID, 8'h00);
		wait_st(8'h01, 8'h01);
		wr(A_FADDR_HIGH, 8'h03);
		wait_st(8'h0A, 8'h08);
		chk(8'(per), 8'h06);
		wr(A_GATE, 8'h00);
		wait_st(8'h26, 8'h00);
		wr(A_TALLY_CTL, 8'h83);
		rdc(A_TALLY_LOW, 8'h01);
		rdc(A_TALLY_MID, 8'h00);
		rdc(A_TALLY_HIGH, 8'h00);
		wr(A_TALLY_CTL, 8'h82);
		rdc(A_TALLY_LOW, 8'h00);
		wr(A_BM_STROBE, 8'h01);
		rdc(A_BM_RDBACK, 8'h00);
		$display("test sector erase done");
		wr(A_GATE, 8'h01);
		wr(A_INSTR, OP_BULK_ERASE);
		wait_st(8'h0A, 8'h08);
		wr(A_GATE, 8'h00);
		wait_st(8'h26, 8'h00);
		for (int s = 0; s < 8; s++) begin
			wr(A_TALLY_CTL, 8'h80 | 8'(s));
			rdc(A_TALLY_LOW, (s == 3) ? 8'h02 : 8'h01);
		end
		$display("test bulk erase done");
		end_sim();
	end
endmodule
